// file: rtl/cnvm_pkg.sv
// Package: register map, field positions, reset values and sequencer types
`default_nettype none
package cnvm_pkg;
	localparam int unsigned REG_W = 16;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned SRC_N = 15;

	// Register offsets
	localparam logic [3:0] PIN_OUTPUT_SELECT_OFS = 4'h2;
	localparam logic [3:0] COMMIT_CHECKSUM_CONTROL_OFS = 4'h3;
	localparam logic [3:0] CHANNEL_POWER_DOWN_OFS = 4'h4;
	localparam logic [3:0] PLL_POWER_DOWN_OFS = 4'h5;

	// Reset values
	localparam logic [15:0] PIN_OUTPUT_SELECT_RST = 16'h0053;
	localparam logic [15:0] COMMIT_CHECKSUM_CONTROL_RST = 16'h0000;
	localparam logic [15:0] CHANNEL_POWER_DOWN_RST = 16'h0054;
	localparam logic [15:0] PLL_POWER_DOWN_RST = 16'h0030;

	// Field positions
	localparam int unsigned PIN1_ROUTE_LSB = 0;
	localparam int unsigned SKIP_CRC_BIT = 15;
	localparam int unsigned CRC_CMD_BIT = 14;
	localparam int unsigned LOAD_CMD_BIT = 13;
	localparam int unsigned STORE_CMD_BIT = 12;
	localparam int unsigned PAGE_BIT = 11;
	localparam int unsigned RSV_SC_HI_BIT = 2;
	localparam int unsigned RSV_SC_LO_BIT = 1;
	localparam int unsigned CHAN4_OFF_BIT = 7;
	localparam int unsigned CHAN3_OFF_BIT = 5;
	localparam int unsigned CHAN2_OFF_BIT = 3;
	localparam int unsigned CHAN1_OFF_BIT = 1;

	// Bits of the control register that hardware clears
	localparam logic [15:0] CTRL_HW_MASK = 16'h7006;

	// Operations handed to the nonvolatile memory engine
	typedef enum logic [1:0]
	{
		CNVM_OP_LOAD = 2'h0,
		CNVM_OP_STORE = 2'h1,
		CNVM_OP_CRC = 2'h2
	} cnvm_op_t;

	// Sequencer states, Gray coded along idle-issue-wait
	typedef enum logic [1:0]
	{
		CNVM_ST_IDLE = 2'h0,
		CNVM_ST_ISSUE = 2'h1,
		CNVM_ST_WAIT = 2'h3
	} cnvm_state_t;
endpackage : cnvm_pkg
`default_nettype wire

// file: rtl/cnvm_route_if.sv
// Interface: status sources and selector between the top and the pin router
`default_nettype none
interface cnvm_route_if;
	import cnvm_pkg::*;
	logic [SEL_W-1:0] sel;
	logic [SRC_N-1:0] src;
	logic pin_out;
	modport drv (output sel, output src, input pin_out);
	modport mux (input sel, input src, output pin_out);
endinterface : cnvm_route_if
`default_nettype wire

// file: rtl/cnvm_pin_router.sv
// Status pin router: picks one of the status sources for the pin
`default_nettype none
module cnvm_pin_router
(
	cnvm_route_if.mux rt
);
	import cnvm_pkg::*;

	// Codes above the last source drive low; clocks pass unregistered
	wire logic in_range;
	assign in_range = (32'(rt.sel) < SRC_N);
	assign rt.pin_out = in_range ? rt.src[rt.sel] : 1'b0;
endmodule : cnvm_pin_router
`default_nettype wire

// file: rtl/cnvm_regs.sv
// Configuration, commit and power-down register slice with commit sequencer
// Overview of operation
// - Pin 1 follows a 4-bit selector, reset 3h, sources in documented order.
// - With skip bit set, soft or pin reset loads skip the checksum.
// - Loads after power-on reset still compute the checksum regardless.
// - Writing one to bit 14 recomputes the checksum, then self-clears.
// - Writing one to bit 13 loads the chosen page into registers.
// - Writing one to bit 12 stores registers into the chosen page.
// - Bit 11 picks page 0 or page 1 for both commits.
// - Power-up load uses the page pin; page bit governs later commits.
// - Control register at 3h resets 0h; reserved bits 2-1 self-clear.
// - Channel power register at 4h resets to 54h.
// - Bits 7 and 5 power down channel 4 and 3 regulators.
// - Bits 3 and 1 power down channel 2 and 1 regulators.
// - PLL power register at 5h resets to 30h.
`default_nettype none
module cnvm_regs
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [cnvm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cnvm_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	output logic [cnvm_pkg::REG_W-1:0] reg_rdata,
	input wire logic page_select_pin,
	input wire logic por_load_req,
	input wire logic rst_load_req,
	output logic nvm_start,
	output cnvm_pkg::cnvm_op_t nvm_op,
	output logic nvm_page,
	output logic nvm_crc_en,
	input wire logic nvm_done,
	input wire logic nvm_wr,
	input wire logic [cnvm_pkg::ADDR_W-1:0] nvm_addr,
	input wire logic [cnvm_pkg::REG_W-1:0] nvm_wdata,
	output logic nvm_busy,
	input wire logic [cnvm_pkg::SRC_N-1:0] status_src,
	output logic pin1_out,
	output logic chan1_reg_off,
	output logic chan2_reg_off,
	output logic chan3_reg_off,
	output logic chan4_reg_off,
	output logic [cnvm_pkg::REG_W-1:0] pll_power_down
);
	import cnvm_pkg::*;

	logic [15:0] pin_output_select_reg;
	logic [15:0] pin_output_select_next;
	logic [15:0] commit_checksum_control_reg;
	logic [15:0] commit_checksum_control_next;
	logic [15:0] channel_power_down_reg;
	logic [15:0] channel_power_down_next;
	logic [15:0] pll_power_down_reg;
	logic [15:0] pll_power_down_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	cnvm_state_t state_reg;
	cnvm_state_t state_next;
	cnvm_op_t op_reg;
	cnvm_op_t op_next;
	logic page_reg;
	logic page_next;
	logic crc_en_reg;
	logic crc_en_next;
	logic cfg_load_reg;
	logic cfg_load_next;
	logic init_done_reg;
	logic init_done_next;
	logic por_pend_reg;
	logic por_pend_next;
	logic rst_pend_reg;
	logic rst_pend_next;
	logic page_meta_reg;
	logic page_sync_reg;

	// Address decode for host and memory-engine writes
	wire logic host_sel_pin;
	wire logic host_sel_ctrl;
	wire logic host_sel_chan;
	wire logic host_sel_pll;
	wire logic nvm_sel_pin;
	wire logic nvm_sel_ctrl;
	wire logic nvm_sel_chan;
	wire logic nvm_sel_pll;
	assign host_sel_pin = reg_wr && (reg_addr == PIN_OUTPUT_SELECT_OFS);
	assign host_sel_ctrl = reg_wr && (reg_addr == COMMIT_CHECKSUM_CONTROL_OFS);
	assign host_sel_chan = reg_wr && (reg_addr == CHANNEL_POWER_DOWN_OFS);
	assign host_sel_pll = reg_wr && (reg_addr == PLL_POWER_DOWN_OFS);
	assign nvm_sel_pin = nvm_wr && (nvm_addr == PIN_OUTPUT_SELECT_OFS);
	assign nvm_sel_ctrl = nvm_wr && (nvm_addr == COMMIT_CHECKSUM_CONTROL_OFS);
	assign nvm_sel_chan = nvm_wr && (nvm_addr == CHANNEL_POWER_DOWN_OFS);
	assign nvm_sel_pll = nvm_wr && (nvm_addr == PLL_POWER_DOWN_OFS);

	// Sequencer side of the control register
	wire logic [15:0] ctrl = commit_checksum_control_reg;
	wire logic idle = (state_reg == CNVM_ST_IDLE);
	wire logic finish = (state_reg == CNVM_ST_WAIT) && nvm_done;
	wire logic fin_store = finish && (op_reg == CNVM_OP_STORE);
	wire logic fin_crc = finish && (op_reg == CNVM_OP_CRC);
	wire logic cmd_load = ctrl[LOAD_CMD_BIT];
	wire logic cmd_store = ctrl[STORE_CMD_BIT];
	wire logic cmd_crc = ctrl[CRC_CMD_BIT];
	wire logic fin_load;
	assign fin_load = finish && !cfg_load_reg && (op_reg == CNVM_OP_LOAD);

	// Hardware clear mask; a host write of one in the same cycle wins
	wire logic [15:0] hw_clr;
	wire logic [15:0] ctrl_held;
	wire logic [15:0] ctrl_nvm;
	assign hw_clr = (16'(fin_crc) << CRC_CMD_BIT)
		| (16'(fin_load) << LOAD_CMD_BIT)
		| (16'(fin_store) << STORE_CMD_BIT)
		| (16'h0001 << RSV_SC_HI_BIT)
		| (16'h0001 << RSV_SC_LO_BIT);
	assign ctrl_held = ctrl & ~hw_clr;
	// A page load keeps pending command bits, replaces the rest
	assign ctrl_nvm = (nvm_wdata & ~CTRL_HW_MASK) | (ctrl_held & CTRL_HW_MASK);

	// Register next values: host write beats a concurrent memory load
	always_comb
	begin
		pin_output_select_next = pin_output_select_reg;
		channel_power_down_next = channel_power_down_reg;
		pll_power_down_next = pll_power_down_reg;
		commit_checksum_control_next = ctrl_held;
		if (nvm_sel_pin)
			pin_output_select_next = nvm_wdata;
		if (nvm_sel_chan)
			channel_power_down_next = nvm_wdata;
		if (nvm_sel_pll)
			pll_power_down_next = nvm_wdata;
		if (nvm_sel_ctrl)
			commit_checksum_control_next = ctrl_nvm;
		if (host_sel_pin)
			pin_output_select_next = reg_wdata;
		if (host_sel_chan)
			channel_power_down_next = reg_wdata;
		if (host_sel_pll)
			pll_power_down_next = reg_wdata;
		if (host_sel_ctrl)
			commit_checksum_control_next = reg_wdata;
	end

	// Sequencer: reset loads first, then load, store, checksum commands
	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		page_next = page_reg;
		crc_en_next = crc_en_reg;
		cfg_load_next = cfg_load_reg;
		init_done_next = init_done_reg;
		por_pend_next = por_pend_reg | por_load_req;
		rst_pend_next = rst_pend_reg | rst_load_req;
		case (state_reg)
			CNVM_ST_IDLE:
			begin
				if (por_pend_reg)
				begin
					state_next = CNVM_ST_ISSUE;
					op_next = CNVM_OP_LOAD;
					page_next = page_sync_reg;
					crc_en_next = 1'b1;
					cfg_load_next = 1'b1;
					por_pend_next = por_load_req;
				end
				else if (rst_pend_reg)
				begin
					state_next = CNVM_ST_ISSUE;
					op_next = CNVM_OP_LOAD;
					page_next = init_done_reg ? ctrl[PAGE_BIT]
						: page_sync_reg;
					crc_en_next = !ctrl[SKIP_CRC_BIT];
					cfg_load_next = 1'b1;
					rst_pend_next = rst_load_req;
				end
				else if (cmd_load || cmd_store || cmd_crc)
				begin
					state_next = CNVM_ST_ISSUE;
					op_next = cmd_load ? CNVM_OP_LOAD
						: (cmd_store ? CNVM_OP_STORE : CNVM_OP_CRC);
					page_next = ctrl[PAGE_BIT];
					crc_en_next = cmd_load && !ctrl[SKIP_CRC_BIT];
					cfg_load_next = 1'b0;
				end
			end
			CNVM_ST_ISSUE:
				state_next = CNVM_ST_WAIT;
			CNVM_ST_WAIT:
			begin
				if (nvm_done)
				begin
					state_next = CNVM_ST_IDLE;
					if (cfg_load_reg)
						init_done_next = 1'b1;
				end
			end
			default:
				state_next = CNVM_ST_IDLE;
		endcase
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		if (reg_addr == PIN_OUTPUT_SELECT_OFS)
			rdata_next = pin_output_select_reg;
		else if (reg_addr == COMMIT_CHECKSUM_CONTROL_OFS)
			rdata_next = ctrl;
		else if (reg_addr == CHANNEL_POWER_DOWN_OFS)
			rdata_next = channel_power_down_reg;
		else if (reg_addr == PLL_POWER_DOWN_OFS)
			rdata_next = pll_power_down_reg;
		else
			rdata_next = 16'h0000;
	end

	// Register bank
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pin_output_select_reg <= PIN_OUTPUT_SELECT_RST;
			commit_checksum_control_reg <= COMMIT_CHECKSUM_CONTROL_RST;
			channel_power_down_reg <= CHANNEL_POWER_DOWN_RST;
			pll_power_down_reg <= PLL_POWER_DOWN_RST;
			rdata_reg <= 16'h0000;
		end
		else
		begin
			pin_output_select_reg <= pin_output_select_next;
			commit_checksum_control_reg <= commit_checksum_control_next;
			channel_power_down_reg <= channel_power_down_next;
			pll_power_down_reg <= pll_power_down_next;
			rdata_reg <= rdata_next;
		end
	end

	// Sequencer state and the page pin synchroniser
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			page_meta_reg <= 1'b0;
			page_sync_reg <= 1'b0;
			state_reg <= CNVM_ST_IDLE;
			op_reg <= CNVM_OP_LOAD;
			page_reg <= 1'b0;
			crc_en_reg <= 1'b0;
			cfg_load_reg <= 1'b0;
			init_done_reg <= 1'b0;
			por_pend_reg <= 1'b0;
			rst_pend_reg <= 1'b0;
		end
		else
		begin
			page_meta_reg <= page_select_pin; // Pin is asynchronous
			page_sync_reg <= page_meta_reg; // Only this flop is read
			state_reg <= state_next;
			op_reg <= op_next;
			page_reg <= page_next;
			crc_en_reg <= crc_en_next;
			cfg_load_reg <= cfg_load_next;
			init_done_reg <= init_done_next;
			por_pend_reg <= por_pend_next;
			rst_pend_reg <= rst_pend_next;
		end
	end

	// Status pin routing through the small router
	cnvm_route_if rt ();
	assign rt.sel = pin_output_select_reg[PIN1_ROUTE_LSB +: SEL_W];
	assign rt.src = status_src;
	cnvm_pin_router u_router
	(
		.rt(rt)
	);
	assign pin1_out = rt.pin_out;

	// Outputs; busy covers the whole transfer so checksum reads wait on it
	assign nvm_busy = !idle;
	assign nvm_start = (state_reg == CNVM_ST_ISSUE);
	assign nvm_op = op_reg;
	assign nvm_page = page_reg;
	assign nvm_crc_en = crc_en_reg;
	assign reg_rdata = rdata_reg;
	assign chan1_reg_off = channel_power_down_reg[CHAN1_OFF_BIT];
	assign chan2_reg_off = channel_power_down_reg[CHAN2_OFF_BIT];
	assign chan3_reg_off = channel_power_down_reg[CHAN3_OFF_BIT];
	assign chan4_reg_off = channel_power_down_reg[CHAN4_OFF_BIT];
	assign pll_power_down = pll_power_down_reg;
endmodule : cnvm_regs
`default_nettype wire

// file: sim/cnvm_sva.sv
// Checker: timing of the slice's register and engine ports
`default_nettype none
module cnvm_sva
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [cnvm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cnvm_pkg::REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [cnvm_pkg::REG_W-1:0] reg_rdata,
	input wire logic nvm_start,
	input wire logic nvm_done,
	input wire logic nvm_busy,
	input wire logic [cnvm_pkg::SRC_N-1:0] status_src,
	input wire logic pin1_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import cnvm_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// A host write to one word
	sequence wr_s(a);
		reg_wr && reg_addr == a;
	endsequence
	// Quiet reads of the control word, long enough to see clearing
	sequence rd3_s;
		(reg_addr == 4'h3 && !reg_wr) [*4];
	endsequence
	pin_route_a: assert property (wr_s(4'h2) ##0 reg_wdata[3:0] != 4'hF
		|=> pin1_out == status_src[$past(reg_wdata[3:0])])
		else $error("pin route wrong");
	sc_clear_a: assert property (wr_s(4'h3) ##1 rd3_s
		|-> reg_rdata[2:1] == 2'h0) else $error("reserved bits stuck");
	cmd_busy_a: assert property (wr_s(4'h3) ##0 reg_wdata[14:12] != 3'h0
		|-> ##[1:3] nvm_busy) else $error("command not taken");
	busy_start_a: assert property ($rose(nvm_busy) |-> ##[0:1] nvm_start)
		else $error("no start after busy");
	start_busy_a: assert property (nvm_start |-> nvm_busy ##1 nvm_busy)
		else $error("start without busy");
	done_idle_a: assert property (nvm_done && nvm_busy && !nvm_start
		|=> !nvm_busy) else $error("busy after done");
	pwr_back_a: assert property (wr_s(4'h4) ##1 reg_addr == 4'h4 && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("power word lost");
	unmapped_zero_a: assert property (reg_addr < 4'h2 || reg_addr > 4'h5
		|=> reg_rdata == 16'h0000) else $error("unmapped read");
endmodule : cnvm_sva
bind cnvm_regs cnvm_sva u_sva (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rdata, .nvm_start, .nvm_done, .nvm_busy, .status_src, .pin1_out);
`default_nettype wire

// file: sim/cnvm_nvm_model.sv
// Partner: behavioural nonvolatile memory engine behind the slice
`default_nettype none
module cnvm_nvm_model
(
	input wire logic clk,
	input wire logic slow,
	input wire logic nvm_start,
	input wire cnvm_pkg::cnvm_op_t nvm_op,
	input wire logic nvm_page,
	output logic nvm_done,
	output logic nvm_wr,
	output logic [cnvm_pkg::ADDR_W-1:0] nvm_addr,
	output logic [cnvm_pkg::REG_W-1:0] nvm_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import cnvm_pkg::*;
	initial
	begin
		nvm_done = 1'b0;
		nvm_wr = 1'b0;
		nvm_addr = 4'h0;
		nvm_wdata = 16'h0000;
	end
	// One answer per start; a load leaves a page-tagged word in 5h
	always @(posedge clk)
		if (nvm_start === 1'b1)
		begin
			repeat (slow ? 5 : 0) @(posedge clk);
			nvm_wr <= (nvm_op == CNVM_OP_LOAD);
			nvm_addr <= PLL_POWER_DOWN_OFS;
			nvm_wdata <= 16'h00A5 ^ 16'(nvm_page);
			@(posedge clk);
			nvm_wr <= 1'b0;
			nvm_wdata <= ~nvm_wdata; // Stale data must not look valid
			nvm_done <= 1'b1;
			@(posedge clk);
			nvm_done <= 1'b0;
		end
endmodule : cnvm_nvm_model
`default_nettype wire

// file: sim/cnvm_regs_tb.sv
// Bench: register slice against a reference model and engine partner
`default_nettype none
module cnvm_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cnvm_pkg::*;
	logic clk = 0, rstn = 0, reg_wr = 0, pin = 0, por = 0, rstl = 0;
	logic slow = 0, nvm_start, nvm_page, nvm_crc_en, nvm_done, nvm_wr;
	logic nvm_busy, pin1, c_pg, c_crc;
	logic [ADDR_W-1:0] reg_addr = 4'h0, nvm_addr;
	logic [REG_W-1:0] reg_wdata = 16'h0000, reg_rdata, nvm_wdata, pll;
	logic [SRC_N-1:0] src = 15'h0000;
	wire logic [3:0] off;
	logic [31:0] seed = 32'h00015387;
	cnvm_op_t nvm_op, c_op;
	int n_mismatch = 0, n_checks = 0, n_start = 0, n_exp = 0;
	int mdl [int]; // Expected register contents by address
	always #5 clk = ~clk;
	cnvm_regs dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
		.page_select_pin(pin), .por_load_req(por), .rst_load_req(rstl),
		.nvm_start, .nvm_op, .nvm_page, .nvm_crc_en, .nvm_done, .nvm_wr,
		.nvm_addr, .nvm_wdata, .nvm_busy, .status_src(src), .pin1_out(pin1),
		.chan1_reg_off(off[0]), .chan2_reg_off(off[1]),
		.chan3_reg_off(off[2]), .chan4_reg_off(off[3]),
		.pll_power_down(pll));
	cnvm_nvm_model nvm (.clk, .slow, .nvm_start, .nvm_op, .nvm_page,
		.nvm_done, .nvm_wr, .nvm_addr, .nvm_wdata);
	// Latch what the engine was asked to do
	always @(posedge clk)
		if (nvm_start === 1'b1)
		begin
			c_op <= nvm_op;
			c_pg <= nvm_page;
			c_crc <= nvm_crc_en;
			n_start++;
		end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Hardware clears the command and reserved self-clearing bits of 3h
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(negedge clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 0;
		mdl[a] = (a == 4'h3) ? d & 16'h8FF9 : d;
	endtask : wr
	task automatic rd(logic [3:0] a);
		reg_addr = a;
		@(negedge clk);
		chk(reg_rdata, mdl.exists(a) ? 16'(mdl[a]) : 16'h0000);
	endtask : rd
	// Bounded wait for the engine; never fewer than three cycles
	task automatic idle();
		for (int i = 0; i < 40 && nvm_busy !== 1'b0 || i < 3; i++)
			@(negedge clk);
	endtask : idle
	task automatic run_op(int w, cnvm_op_t op, logic pg, logic crc);
		@(negedge clk);
		por = (w == 1);
		rstl = (w == 2);
		@(negedge clk);
		por = 0;
		rstl = 0;
		n_exp++;
		idle();
		chk(16'(nvm_busy), 16'h0000);
		chk(16'(n_start), 16'(n_exp));
		chk(16'(c_op), 16'(op));
		chk(16'(c_pg), 16'(pg));
		if (op == CNVM_OP_LOAD)
			chk(16'(c_crc), 16'(crc));
	endtask : run_op
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Cut a hang short far beyond the few hundred cycles expected
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		logic [15:0] d;
		mdl[2] = 16'h0053;
		mdl[3] = 16'h0000;
		mdl[4] = 16'h0054;
		mdl[5] = 16'h0030;
		src = 15'(rnd());
		repeat (4) @(negedge clk);
		rstn = 1;
		for (int a = 0; a < 16; a++)
			rd(4'(a));
		chk(16'(off), 16'h0000);
		chk(16'(pin1), 16'(src[3]));
		$display("test reset done");
		for (int k = 0; k < 16; k++)
		begin
			wr(4'h2, 16'(rnd()) & 16'hFFF0 | 16'(k));
			src = 15'(rnd());
			#1;
			chk(16'(pin1), k < 15 ? 16'(src[k]) : 16'h0000);
			rd(4'h2);
		end
		$display("test routing done");
		repeat (4)
		begin
			wr(4'h4, 16'(rnd()));
			rd(4'h4);
			chk(16'(off), 16'({mdl[4][7], mdl[4][5], mdl[4][3], mdl[4][1]}));
			wr(4'h5, 16'(rnd()));
			chk(pll, 16'(mdl[5]));
		end
		$display("test power done");
		// Every command on both pages, engine prompt then stalling
		for (int c = 0; c < 12; c++)
		begin
			slow = (c >= 6);
			d = 16'(rnd()) & 16'h87F9 | 16'h0006 | 16'h1000 << (c % 3)
				| 16'(c / 3 % 2) << 11;
			wr(4'h3, d);
			@(negedge clk);
			chk(reg_rdata & 16'h7000, d & 16'h7000);
			run_op(0, c % 3 == 1 ? CNVM_OP_LOAD : c % 3 ? CNVM_OP_CRC
				: CNVM_OP_STORE, d[11], !d[15]);
			if (c % 3 == 1)
				mdl[5] = 16'h00A5 ^ 16'(d[11]);
			rd(4'h3);
			rd(4'h5);
		end
		$display("test commits done");
		pin = 1;
		wr(4'h3, 16'h8000);
		run_op(2, CNVM_OP_LOAD, 1'b1, 1'b0);
		run_op(1, CNVM_OP_LOAD, 1'b1, 1'b1);
		run_op(2, CNVM_OP_LOAD, 1'b0, 1'b0);
		wr(4'h3, 16'h0000);
		run_op(2, CNVM_OP_LOAD, 1'b0, 1'b1);
		mdl[5] = 16'h00A5;
		rd(4'h5);
		$display("test config loads done");
		end_of_test();
	end
endmodule : cnvm_regs_tb
`default_nettype wire
